// ---- logic/wdt_defs_defs.vh ----
// Purpose: constants shared by the watchdog and power-fail supervisor
// Assumes: included by bare name from the design file
// Notes: offsets are register addresses on the plain register port
`ifndef WDT_DEFS_DEFS_VH
`define WDT_DEFS_DEFS_VH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_CLOCK_CONTROL 8'h8E
`define ADDR_SUPERVISOR_CONTROL 8'hD8
`define ADDR_EXT_IRQ_ENABLE 8'hE8
`define ADDR_EXT_IRQ_FLAGS 8'h91
`define ADDR_TIMED_ACCESS 8'hC7
`define ADDR_IRQ_STATUS 8'hF0
`define ADDR_IRQ_MASK 8'hF1
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CKC_PERIOD_HI 7
`define CKC_PERIOD_LO 6
`define SUP_PF_EN 5
`define SUP_PF_FLAG 4
`define SUP_WD_RST_FLAG 3
`define SUP_WD_IRQ_FLAG 2
`define SUP_WD_RST_EN 1
`define SUP_WD_RESTART 0
`define EIE_WD_IRQ_EN 4
`define EXF_STOP_REF_KEEP 0
`define IST_WD_IRQ 0
`define IST_PF_WARN 1
`define IST_WD_RST 2
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_IRQ3 3'h0
// ------------------------------------------------------------
// timing counts in crystal clocks
// ------------------------------------------------------------
`define POR_CYCLES 65536
`define WD_TIMEOUT_00 131072
`define WD_TIMEOUT_01 1048576
`define WD_TIMEOUT_10 8388608
`define WD_TIMEOUT_11 67108864
`define WD_EARLY_CYCLES 512
`define CPU_RESET_STRETCH 4
`define TA_WINDOW 3
// ------------------------------------------------------------
// keys and vectors
// ------------------------------------------------------------
`define TA_KEY1 8'hAA
`define TA_KEY2 8'h55
`define PF_VECTOR 16'h0033
`define NO_VECTOR 16'h0000
`endif

// ---- logic/watchdog_power_fail_supervisor.v ----
// Purpose: crystal-clocked watchdog plus power-on, brownout and
//          early-warning power-fail supervision for a small cpu
// Assumes: clock is the crystal clock; comparator inputs are async
// Notes: registers reached by addr/wdata/wr/rd, read data next cycle
`include "wdt_defs_defs.vh"

// Notes on behaviour
// RULE1 - The two-bit period field picks an interrupt timeout of 2^17, 2^20, 2^23 or 2^26 clocks.
// RULE2 - The period field sits in bits 7 and 6 of clock_control.
// RULE3 - The interrupt flag sets 512 clocks before the reset flag would.
// RULE4 - The watchdog counter advances on every crystal clock.
// RULE5 - The counter runs freely, flags at the timeout and restarts from zero on command.
// RULE6 - With reset enabled, reaching the reset timeout sets the reset flag and resets the cpu.
// RULE7 - Reset enable and restart bits change only through a timed-access write.
// RULE8 - The watchdog interrupt has its own enable, independent of the reset enable.
// RULE9 - An enabled watchdog interrupt wakes the cpu from power-saving modes.
// RULE10 - An enabled power-fail warning requests the vector 0033h.
// RULE11 - The power-fail request outranks every other interrupt source.
// RULE12 - Bit 5 of supervisor_control enables the power-fail interrupt.
// RULE13 - Bit 4 of supervisor_control is a sticky power-fail flag cleared only by software.
// RULE14 - At power-up reset holds until supply is good, then the oscillator runs 65,536 clocks before release.
// RULE15 - A supply below the reset threshold asserts and holds reset with no software action; the code ignores it in stop mode with the reference off.
// RULE16 - Bit 0 of extended_interrupt_flags keeps the reference alive in stop mode, reset value 0.
// RULE17 - A timed-access write counts only right after the two-byte unlock within a short window.
module watchdog_power_fail_supervisor #(
  parameter integer POR_CYCLES = `POR_CYCLES,
  parameter integer TIMEOUT0 = `WD_TIMEOUT_00,
  parameter integer TIMEOUT1 = `WD_TIMEOUT_01,
  parameter integer TIMEOUT2 = `WD_TIMEOUT_10,
  parameter integer TIMEOUT3 = `WD_TIMEOUT_11,
  parameter integer CNT_W = 27,
  parameter integer POR_W = 17
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  input wire supply_below_reset,
  input wire supply_below_warning,
  input wire stop_mode,
  output reg cpu_reset_ff,
  output reg osc_enable_ff,
  output reg pf_irq_req_ff,
  output reg wd_irq_req_ff,
  output reg [15:0] irq_vector_ff,
  output reg wake_ff,
  output reg irq_ff
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_POR = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  localparam [1:0] TA_IDLE = 2'd0;
  localparam [1:0] TA_HALF = 2'd1;
  localparam [1:0] TA_OPEN = 2'd2;
  // integer forms first, then cut to the counter widths on purpose
  localparam integer IRQ_LAST0 = TIMEOUT0 - 1;
  localparam integer IRQ_LAST1 = TIMEOUT1 - 1;
  localparam integer IRQ_LAST2 = TIMEOUT2 - 1;
  localparam integer IRQ_LAST3 = TIMEOUT3 - 1;
  localparam integer EARLY_INT = `WD_EARLY_CYCLES;
  localparam integer POR_LAST_INT = POR_CYCLES - 1;
  localparam integer TA_LEN_INT = `TA_WINDOW;
  localparam integer RST_LEN_INT = `CPU_RESET_STRETCH;
  localparam [CNT_W-1:0] IRQ_PT0 = IRQ_LAST0[CNT_W-1:0];
  localparam [CNT_W-1:0] IRQ_PT1 = IRQ_LAST1[CNT_W-1:0];
  localparam [CNT_W-1:0] IRQ_PT2 = IRQ_LAST2[CNT_W-1:0];
  localparam [CNT_W-1:0] IRQ_PT3 = IRQ_LAST3[CNT_W-1:0];
  localparam [CNT_W-1:0] EARLY = EARLY_INT[CNT_W-1:0];
  localparam [POR_W-1:0] POR_LAST = POR_LAST_INT[POR_W-1:0];
  localparam [1:0] TA_LEN = TA_LEN_INT[1:0];
  localparam [2:0] RST_LEN = RST_LEN_INT[2:0];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [2:0] rst_sync_ff;
  reg [2:0] warn_sync_ff;
  reg below_rst_ff;
  reg below_warn_ff;
  reg [2:0] state_ff;
  reg [POR_W-1:0] por_cnt_ff;
  reg [CNT_W-1:0] wd_cnt_ff;
  reg [2:0] rst_stretch_ff;
  reg [7:0] clock_control_ff;
  reg pf_en_ff;
  reg pf_flag_ff;
  reg wd_rst_flag_ff;
  reg wd_irq_flag_ff;
  reg wd_rst_en_ff;
  reg [7:0] ext_irq_enable_ff;
  reg stop_ref_keep_ff;
  reg [1:0] ta_stage_ff;
  reg [1:0] ta_timer_ff;
  reg [2:0] irq_status_ff;
  reg [2:0] irq_mask_ff;
  reg warn_seen_ff;

  // ------------------------------------------------------------
  // decode and derived terms
  // ------------------------------------------------------------
  wire wr_ckc = wr && (addr == `ADDR_CLOCK_CONTROL);
  wire wr_sup = wr && (addr == `ADDR_SUPERVISOR_CONTROL);
  wire wr_eie = wr && (addr == `ADDR_EXT_IRQ_ENABLE);
  wire wr_exf = wr && (addr == `ADDR_EXT_IRQ_FLAGS);
  wire wr_ta = wr && (addr == `ADDR_TIMED_ACCESS);
  wire wr_ist = wr && (addr == `ADDR_IRQ_STATUS);
  wire wr_imk = wr && (addr == `ADDR_IRQ_MASK);
  // a protected write only counts while the unlock is open
  wire ta_ok = wr_sup && (ta_stage_ff == TA_OPEN); // RULE7 RULE17
  wire restart = ta_ok && wdata[`SUP_WD_RESTART]; // RULE5 RULE7
  // reference off in stop mode unless software keeps it alive
  wire ref_on = !stop_mode || stop_ref_keep_ff; // RULE16
  wire brownout = below_rst_ff && ref_on; // RULE15
  wire warn = below_warn_ff && ref_on;
  wire running = (state_ff == ST_RUN);
  wire [1:0] period = {clock_control_ff[`CKC_PERIOD_HI],
                       clock_control_ff[`CKC_PERIOD_LO]}; // RULE2
  reg [CNT_W-1:0] irq_point;
  wire [CNT_W-1:0] rst_point = irq_point + EARLY; // RULE3
  wire hit_irq = running && (wd_cnt_ff == irq_point);
  wire hit_rst = running && (wd_cnt_ff == rst_point);
  wire wd_rst_fire = hit_rst && wd_rst_en_ff; // RULE6
  wire pf_req = pf_en_ff && warn; // RULE10 RULE12
  wire wd_irq_en = ext_irq_enable_ff[`EIE_WD_IRQ_EN];
  wire [2:0] ev = {wd_rst_fire, warn && !warn_seen_ff, hit_irq};

  // timeout selection by the period field
  always @* begin
    case (period) // RULE1
      2'b00: irq_point = IRQ_PT0;
      2'b01: irq_point = IRQ_PT1;
      2'b10: irq_point = IRQ_PT2;
      default: irq_point = IRQ_PT3;
    endcase
  end

  // ------------------------------------------------------------
  // comparator synchronisers
  // ------------------------------------------------------------
  // three stages; a level is taken only when stages two and three
  // agree, which filters a single-cycle disagreement from the pin
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 3'h7;
      warn_sync_ff <= 3'h0;
      below_rst_ff <= 1'b1;
      below_warn_ff <= 1'b0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[1:0], supply_below_reset};
      warn_sync_ff <= {warn_sync_ff[1:0], supply_below_warning};
      if (rst_sync_ff[1] == rst_sync_ff[2]) begin
        below_rst_ff <= rst_sync_ff[2];
      end
      if (warn_sync_ff[1] == warn_sync_ff[2]) begin
        below_warn_ff <= warn_sync_ff[2];
      end
    end
  end

  // ------------------------------------------------------------
  // power-on and brownout sequencer
  // ------------------------------------------------------------
  // hold while supply is low, then run the oscillator for the
  // power-on interval; a brownout at any time drops back to hold
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_HOLD;
      por_cnt_ff <= {POR_W{1'b0}};
      osc_enable_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_HOLD: begin
          por_cnt_ff <= {POR_W{1'b0}};
          if (!brownout) begin
            state_ff <= ST_POR; // RULE14
            osc_enable_ff <= 1'b1;
          end
        end
        ST_POR: begin
          if (brownout) begin
            state_ff <= ST_HOLD; // RULE15
          end else if (por_cnt_ff == POR_LAST) begin
            state_ff <= ST_RUN; // RULE14
          end else begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
          end
        end
        ST_RUN: begin
          if (brownout) begin
            state_ff <= ST_HOLD; // RULE15
          end
        end
        default: state_ff <= ST_HOLD;
      endcase
    end
  end

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  // counts every crystal clock while the cpu runs; wraps at the
  // reset point so the early interrupt can act as a time base
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= {CNT_W{1'b0}};
    end else if (!running || restart || hit_rst) begin
      wd_cnt_ff <= {CNT_W{1'b0}}; // RULE5
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 1'b1; // RULE4
    end
  end

  // ------------------------------------------------------------
  // cpu reset output
  // ------------------------------------------------------------
  // a watchdog reset is stretched so the core sees a clean pulse
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_stretch_ff <= 3'h0;
      cpu_reset_ff <= 1'b1;
    end else begin
      if (wd_rst_fire) begin
        rst_stretch_ff <= RST_LEN; // RULE6
      end else if (rst_stretch_ff != 3'h0) begin
        rst_stretch_ff <= rst_stretch_ff - 1'b1;
      end
      cpu_reset_ff <= !running || wd_rst_fire || (rst_stretch_ff > 3'h1);
    end
  end

  // ------------------------------------------------------------
  // timed-access unlock
  // ------------------------------------------------------------
  // two keys in order, each step must land before the window ends;
  // the window keeps a runaway loop from reaching the protected bits
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ta_stage_ff <= TA_IDLE;
      ta_timer_ff <= 2'h0;
    end else if (wr_ta && wdata == `TA_KEY1) begin
      ta_stage_ff <= TA_HALF; // RULE17
      ta_timer_ff <= TA_LEN;
    end else if (wr_ta && wdata == `TA_KEY2 && ta_stage_ff == TA_HALF) begin
      ta_stage_ff <= TA_OPEN; // RULE17
      ta_timer_ff <= TA_LEN;
    end else if (wr_ta || ta_ok || ta_timer_ff == 2'h0) begin
      ta_stage_ff <= TA_IDLE; // RULE17
      ta_timer_ff <= 2'h0;
    end else begin
      ta_timer_ff <= ta_timer_ff - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // flags: hardware set wins over a software clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_ff <= `RST_BYTE;
      pf_en_ff <= 1'b0;
      pf_flag_ff <= 1'b0;
      wd_rst_flag_ff <= 1'b0;
      wd_irq_flag_ff <= 1'b0;
      wd_rst_en_ff <= 1'b0;
      ext_irq_enable_ff <= `RST_BYTE;
      stop_ref_keep_ff <= 1'b0; // RULE16
      irq_mask_ff <= `RST_IRQ3;
      warn_seen_ff <= 1'b0;
    end else begin
      warn_seen_ff <= warn;
      if (wr_ckc) begin
        clock_control_ff <= wdata; // RULE2
      end
      if (wr_eie) begin
        ext_irq_enable_ff <= wdata; // RULE8
      end
      if (wr_exf) begin
        stop_ref_keep_ff <= wdata[`EXF_STOP_REF_KEEP]; // RULE16
      end
      if (wr_imk) begin
        irq_mask_ff <= wdata[2:0];
      end
      if (wr_sup) begin
        pf_en_ff <= wdata[`SUP_PF_EN]; // RULE12
      end
      if (ta_ok) begin
        wd_rst_en_ff <= wdata[`SUP_WD_RST_EN]; // RULE7
      end
      // power-fail flag follows any warning, enable or not
      if (warn) begin
        pf_flag_ff <= 1'b1; // RULE13
      end else if (wr_sup && !wdata[`SUP_PF_FLAG]) begin
        pf_flag_ff <= 1'b0; // RULE13
      end
      if (hit_irq) begin
        wd_irq_flag_ff <= 1'b1; // RULE3
      end else if (wr_sup && !wdata[`SUP_WD_IRQ_FLAG]) begin
        wd_irq_flag_ff <= 1'b0;
      end
      if (wd_rst_fire) begin
        wd_rst_flag_ff <= 1'b1; // RULE6
      end else if (wr_sup && !wdata[`SUP_WD_RST_FLAG]) begin
        wd_rst_flag_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status and line
  // ------------------------------------------------------------
  // sticky events, write one to clear, set wins over clear
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= `RST_IRQ3;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= ev | (irq_status_ff & ~(wr_ist ? wdata[2:0] : 3'h0));
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ------------------------------------------------------------
  // requests to the cpu
  // ------------------------------------------------------------
  // power-fail blocks the watchdog request so the core never sees
  // two sources in one cycle; the watchdog one returns afterwards
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pf_irq_req_ff <= 1'b0;
      wd_irq_req_ff <= 1'b0;
      irq_vector_ff <= `NO_VECTOR;
      wake_ff <= 1'b0;
    end else begin
      pf_irq_req_ff <= pf_req; // RULE10
      wd_irq_req_ff <= wd_irq_flag_ff && wd_irq_en && !pf_req; // RULE8 RULE11
      irq_vector_ff <= pf_req ? `PF_VECTOR : `NO_VECTOR; // RULE10 RULE11
      wake_ff <= pf_req || (wd_irq_flag_ff && wd_irq_en); // RULE9
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // data stands one cycle after the strobe and is zero otherwise
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `RST_BYTE;
    end else if (!rd) begin
      rdata_ff <= `RST_BYTE;
    end else if (addr == `ADDR_CLOCK_CONTROL) begin
      rdata_ff <= clock_control_ff;
    end else if (addr == `ADDR_SUPERVISOR_CONTROL) begin
      rdata_ff <= {2'b00, pf_en_ff, pf_flag_ff, wd_rst_flag_ff,
                   wd_irq_flag_ff, wd_rst_en_ff, 1'b0};
    end else if (addr == `ADDR_EXT_IRQ_ENABLE) begin
      rdata_ff <= ext_irq_enable_ff;
    end else if (addr == `ADDR_EXT_IRQ_FLAGS) begin
      rdata_ff <= {7'h00, stop_ref_keep_ff};
    end else if (addr == `ADDR_IRQ_STATUS) begin
      rdata_ff <= {5'h00, irq_status_ff};
    end else if (addr == `ADDR_IRQ_MASK) begin
      rdata_ff <= {5'h00, irq_mask_ff};
    end else begin
      rdata_ff <= `RST_BYTE;
    end
  end

endmodule

// ---- tb/watchdog_power_fail_supervisor_assertions.sv ----
// Purpose: concurrent checks on the supervisor ports
// Assumes: one clock domain, asynchronous active-low rst_n
// Notes: the power-on bounds follow POR_CYCLES handed over by the bind
module watchdog_power_fail_supervisor_checker #(
  parameter integer POR_CYCLES = 16
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_ff,
  input wire supply_below_reset,
  input wire supply_below_warning,
  input wire stop_mode,
  input wire cpu_reset_ff,
  input wire osc_enable_ff,
  input wire pf_irq_req_ff,
  input wire wd_irq_req_ff,
  input wire [15:0] irq_vector_ff,
  input wire wake_ff,
  input wire irq_ff
);
  localparam int POR_LO = POR_CYCLES - 1;
  localparam int POR_HI = POR_CYCLES + 2;
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // read data stays clear unless a read was taken on the edge before
  chk_rdata_idle: assert property (!$past(rd) |-> rdata_ff == 8'h00)
    else $error("read data seen without a read");
  chk_vector_pf: assert property (irq_vector_ff == (pf_irq_req_ff ? 16'h0033 : 16'h0000))
    else $error("vector does not follow the power-fail request");
  chk_pf_priority: assert property (pf_irq_req_ff |-> !wd_irq_req_ff)
    else $error("watchdog request beside a power-fail request");
  // comparator goes through a synchronizer, so allow six samples
  chk_brownout_hold: assert property ((supply_below_reset && !stop_mode) [*6] |=> cpu_reset_ff)
    else $error("low supply without cpu reset");
  chk_por_count: assert property ($rose(osc_enable_ff) |-> ##[POR_LO:POR_HI] $fell(cpu_reset_ff))
    else $error("power-on interval has the wrong length");
  chk_osc_gates_run: assert property (!osc_enable_ff |-> cpu_reset_ff)
    else $error("cpu released with oscillator off");
  chk_wd_wake: assert property ($rose(wd_irq_req_ff) |-> ##[0:2] wake_ff)
    else $error("watchdog request gave no wake");
  chk_pf_quiet: assert property ((!supply_below_warning) [*6] |=> !pf_irq_req_ff)
    else $error("power-fail request without warning");
endmodule

bind watchdog_power_fail_supervisor watchdog_power_fail_supervisor_checker #(.POR_CYCLES(POR_CYCLES)) checker_i (
  .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .supply_below_reset(supply_below_reset), .supply_below_warning(supply_below_warning),
  .stop_mode(stop_mode), .cpu_reset_ff(cpu_reset_ff), .osc_enable_ff(osc_enable_ff),
  .pf_irq_req_ff(pf_irq_req_ff), .wd_irq_req_ff(wd_irq_req_ff), .irq_vector_ff(irq_vector_ff),
  .wake_ff(wake_ff), .irq_ff(irq_ff)
);

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the watchdog and power-fail supervisor
// Assumes: short counts set through the design parameters
// Notes: power-on checks first, then the register table loop, timing and fault cases after it
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 16;
  localparam int TO [4] = '{64, 128, 256, 512};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic supply_below_reset = 1'b1;
  logic supply_below_warning = 1'b0;
  logic stop_mode = 1'b0;
  logic [7:0] rdata_ff;
  logic cpu_reset_ff, osc_enable_ff, pf_irq_req_ff, wd_irq_req_ff, wake_ff, irq_ff;
  logic [15:0] irq_vector_ff;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  // rows: address, write value, expected read back
  logic [7:0] tbl [7][3] = '{'{8'h8E, 8'hC0, 8'hC0}, '{8'hD8, 8'h23, 8'h20}, '{8'hE8, 8'h10, 8'h10},
    '{8'h91, 8'h01, 8'h01}, '{8'hF1, 8'h07, 8'h07}, '{8'h3A, 8'hAA, 8'h00}, '{8'hF0, 8'h07, 8'h00}};

  watchdog_power_fail_supervisor #(.POR_CYCLES(POR), .TIMEOUT0(64), .TIMEOUT1(128), .TIMEOUT2(256),
    .TIMEOUT3(512)) watchdog_power_fail_supervisor_i (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .supply_below_reset(supply_below_reset), .supply_below_warning(supply_below_warning),
    .stop_mode(stop_mode), .cpu_reset_ff(cpu_reset_ff), .osc_enable_ff(osc_enable_ff),
    .pf_irq_req_ff(pf_irq_req_ff), .wd_irq_req_ff(wd_irq_req_ff), .irq_vector_ff(irq_vector_ff),
    .wake_ff(wake_ff), .irq_ff(irq_ff)
  );

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  always #12.5 clock = ~clock;
  // whole run is near 1900 cycles, so this only trips on a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [7:0] m, logic [7:0] exp, string name);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(name, {8'h00, exp}, {8'h00, rdata_ff & m});
  endtask
  // unlock pair then the protected write; a wrong second key must lock it out
  task automatic twr(logic [7:0] key2, logic [7:0] d);
    wreg(8'hC7, 8'hAA);
    wreg(8'hC7, key2);
    wreg(8'hD8, d);
  endtask
  // bounded wait: 0 watchdog request, 1 reset high, 2 reset low, 3 oscillator on
  task automatic wait_on(int s, output int k);
    k = 0;
    while (!(s == 0 ? wd_irq_req_ff === 1'b1 : s == 1 ? cpu_reset_ff === 1'b1 :
        s == 2 ? cpu_reset_ff === 1'b0 : osc_enable_ff === 1'b1) && k < 3000) begin
      @(posedge clock);
      #1;
      k++;
    end
    // a wait that runs out is a mismatch, so a hang never reads as a pass
    if (k >= 3000) begin
      num_errors++;
      $display("[FAIL] wait event %0d expected 1 seen 0", s);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    tick(8);
    chk("reset while supply low", 16'h0001, {15'h0, cpu_reset_ff});
    chk("oscillator while supply low", 16'h0000, {15'h0, osc_enable_ff});
    @(posedge clock);
    supply_below_reset <= 1'b0;
    wait_on(3, n);
    wait_on(2, n);
    chk("power-on interval", 16'h0001, {15'h0, n >= POR - 1 && n <= POR + 1});
    foreach (tbl[i]) begin
      wreg(tbl[i][0], tbl[i][1]);
      rreg(tbl[i][0], 8'hFF, tbl[i][2], $sformatf("register %h", tbl[i][0]));
    end
    // every period: restart, then time the early interrupt
    for (int s = 0; s < 4; s++) begin
      wreg(8'h8E, {s[1:0], 6'h00});
      twr(8'h55, 8'h21);
      tick(2);
      chk("request after restart", 16'h0000, {15'h0, wd_irq_req_ff});
      wait_on(0, n);
      chk("interrupt timeout", 16'h0001, {15'h0, n + 2 >= TO[s] && n + 2 <= TO[s] + 2});
    end
    chk("wake from watchdog", 16'h0001, {15'h0, wake_ff});
    chk("interrupt line", 16'h0001, {15'h0, irq_ff});
    rreg(8'hF0, 8'h07, 8'h01, "status");
    wreg(8'hF1, 8'h00);
    tick(2);
    chk("masked interrupt line", 16'h0000, {15'h0, irq_ff});
    wreg(8'hF1, 8'h07);
    wreg(8'hF0, 8'h07);
    tick(2);
    chk("cleared interrupt line", 16'h0000, {15'h0, irq_ff});
    // reset enabled: reset follows the interrupt by 512 clocks and lasts 4
    wreg(8'h8E, 8'h00);
    twr(8'h55, 8'h23);
    tick(2);
    wait_on(0, n);
    wait_on(1, n);
    chk("interrupt to reset gap", 16'h0001, {15'h0, n >= 511 && n <= 513});
    tick(3);
    chk("watchdog reset held", 16'h0001, {15'h0, cpu_reset_ff});
    tick(2);
    chk("watchdog reset ends", 16'h0000, {15'h0, cpu_reset_ff});
    rreg(8'hD8, 8'h08, 8'h08, "reset flag");
    twr(8'h55, 8'h20);
    twr(8'h56, 8'h22);
    rreg(8'hD8, 8'h02, 8'h00, "enable after bad key");
    // watchdog interrupt gated by its own enable and by a power-fail request
    wreg(8'hE8, 8'h00);
    twr(8'h55, 8'h21);
    tick(70);
    chk("request with enable off", 16'h0000, {15'h0, wd_irq_req_ff});
    chk("wake with enable off", 16'h0000, {15'h0, wake_ff});
    rreg(8'hD8, 8'h04, 8'h04, "interrupt flag");
    wreg(8'hE8, 8'h10);
    @(posedge clock);
    supply_below_warning <= 1'b1;
    tick(6);
    chk("power-fail request", 16'h0001, {15'h0, pf_irq_req_ff});
    chk("power-fail vector", 16'h0033, irq_vector_ff);
    chk("watchdog request yields", 16'h0000, {15'h0, wd_irq_req_ff});
    @(posedge clock);
    supply_below_warning <= 1'b0;
    tick(6);
    chk("request after warning", 16'h0000, {15'h0, pf_irq_req_ff});
    rreg(8'hD8, 8'h10, 8'h10, "sticky power-fail flag");
    wreg(8'hD8, 8'h00);
    rreg(8'hD8, 8'h10, 8'h00, "power-fail flag cleared");
    @(posedge clock);
    supply_below_warning <= 1'b1;
    tick(6);
    chk("request with enable off", 16'h0000, {15'h0, pf_irq_req_ff});
    rreg(8'hD8, 8'h10, 8'h10, "flag with enable off");
    // stop mode: reference off hides the warning, keep bit restores it
    wreg(8'h91, 8'h00);
    stop_mode <= 1'b1;
    wreg(8'hD8, 8'h00);
    tick(6);
    rreg(8'hD8, 8'h10, 8'h00, "stop without reference");
    wreg(8'h91, 8'h01);
    tick(6);
    rreg(8'hD8, 8'h10, 8'h10, "stop with reference");
    @(posedge clock);
    stop_mode <= 1'b0;
    supply_below_warning <= 1'b0;
    @(posedge clock);
    supply_below_reset <= 1'b1;
    tick(8);
    chk("brownout reset", 16'h0001, {15'h0, cpu_reset_ff});
    @(posedge clock);
    supply_below_reset <= 1'b0;
    wait_on(2, n);
    // second reset in mid-run, then the register reset values
    @(posedge clock);
    rst_n <= 1'b0;
    tick(2);
    chk("reset during rst_n", 16'h0001, {15'h0, cpu_reset_ff});
    @(posedge clock);
    rst_n <= 1'b1;
    wait_on(2, n);
    rreg(8'h8E, 8'hFF, 8'h00, "clock_control reset");
    rreg(8'hD8, 8'hFF, 8'h00, "supervisor_control reset");
    rreg(8'h91, 8'hFF, 8'h00, "extended_interrupt_flags reset");
    rreg(8'hE8, 8'hFF, 8'h00, "extended_interrupt_enable reset");
    wrap_up();
  end
endmodule
